// ==== nccs_bus_cycle.sv ====
// Pin engine that runs one strobed command, address or data cycle.
module nccs_bus_cycle (
    // Clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       srst_i,
    // Request channel
    nccs_cyc_if.eng         cyc,
    // Device pins
    output logic            cle_o,
    output logic            ale_o,
    output logic            ce_n_o,
    output logic            we_n_o,
    output logic            re_n_o,
    output logic [7:0]      dq_o,
    output logic            dq_oe_o,
    input  wire logic [7:0] dq_i
);
    import nccs_pkg::*;

    typedef enum logic [2:0] {
        E_IDLE  = 3'b000,
        E_SETUP = 3'b001,
        E_LOW   = 3'b011,
        E_HOLD  = 3'b010,
        E_HIGH  = 3'b110
    } nccs_eng_t;

    nccs_eng_t  st_reg, st_next;
    logic [2:0] div_reg, div_next;
    logic       cle_next, ale_next, we_next, re_next, oe_next, done_next;
    logic [7:0] dq_next, rb_next;
    logic       rd_reg, rd_next;
    logic [7:0] s1_reg, s2_reg, s3_reg, rbyte_reg;
    logic       tick;

    // One divider period per strobe phase meets the least pulse width.
    assign tick = (div_reg == 3'(STROBE_CYC - 1));

    always_comb begin
        st_next   = st_reg;
        div_next  = tick ? 3'h0 : div_reg + 3'h1;
        cle_next  = cle_o;
        ale_next  = ale_o;
        we_next   = we_n_o;
        re_next   = re_n_o;
        oe_next   = dq_oe_o;
        dq_next   = dq_o;
        rd_next   = rd_reg;
        done_next = 1'b0;
        rb_next   = rbyte_reg;
        unique case (st_reg)
            E_IDLE: begin
                if (cyc.req) begin
                    cle_next = (cyc.kind == CYC_CMD);
                    ale_next = (cyc.kind == CYC_ADDR);
                    rd_next  = (cyc.kind == CYC_RD);
                    oe_next  = (cyc.kind != CYC_RD);
                    dq_next  = cyc.wbyte;
                    div_next = 3'h0;
                    st_next  = E_SETUP;
                end
            end
            E_SETUP: begin
                if (tick) begin
                    we_next = rd_reg;
                    re_next = !rd_reg;
                    st_next = E_LOW;
                end
            end
            E_LOW: begin
                if (tick) begin
                    st_next = rd_reg ? E_HOLD : E_HIGH;
                    we_next = 1'b1;
                end
            end
            E_HOLD: begin
                // Data pins pass three flops, so reads hold the strobe low longer.
                if (tick) begin
                    rb_next = (s2_reg == s3_reg) ? s3_reg : rbyte_reg;
                    re_next = 1'b1;
                    st_next = E_HIGH;
                end
            end
            E_HIGH: begin
                if (tick) begin
                    cle_next  = 1'b0;
                    ale_next  = 1'b0;
                    oe_next   = 1'b0;
                    done_next = 1'b1;
                    st_next   = E_IDLE;
                end
            end
            default: st_next = E_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            st_reg    <= E_IDLE;
            div_reg   <= 3'h0;
            cle_o     <= 1'b0;
            ale_o     <= 1'b0;
            ce_n_o    <= 1'b1;
            we_n_o    <= 1'b1;
            re_n_o    <= 1'b1;
            dq_o      <= 8'h00;
            dq_oe_o   <= 1'b0;
            rd_reg    <= 1'b0;
            cyc.done  <= 1'b0;
            rbyte_reg <= 8'h00;
            s1_reg    <= 8'h00;
            s2_reg    <= 8'h00;
            s3_reg    <= 8'h00;
        end else begin
            st_reg    <= st_next;
            div_reg   <= div_next;
            cle_o     <= cle_next;
            ale_o     <= ale_next;
            ce_n_o    <= !cyc.ce_en;
            we_n_o    <= we_next;
            re_n_o    <= re_next;
            dq_o      <= dq_next;
            dq_oe_o   <= oe_next;
            rd_reg    <= rd_next;
            cyc.done  <= done_next;
            rbyte_reg <= rb_next;
            s1_reg    <= dq_i;
            s2_reg    <= s1_reg;
            s3_reg    <= s2_reg;
        end
    end

    assign cyc.rbyte = rbyte_reg;
endmodule

// ==== nccs_ctrl.sv ====
// Host controller sequencing NAND cache program, page program, erase and status reads.
// Overview of operation
// R01 - The device holds cache and data registers of 2112 bytes or 1056 words.
// R02 - All pages of one cache programming sequence stay inside one block; the code checks only the 15h pages, not the closing 10h page.
// R03 - Program starts with 80h, four address cycles, then page data.
// R04 - Command 15h makes the device busy briefly, then ready for another sequence.
// R05 - Later 15h sequences stay busy until current cell programming finishes.
// R06 - Read status 70h is accepted during cache programming and reports results.
// R07 - Status bit 6 is one when the cache register accepts new data.
// R08 - Status bit 5 is one when cell programming is idle.
// R09 - Status bit 1 gives page N-1 pass or fail once bit 6 is one.
// R10 - Status bit 0 gives page N pass or fail once bit 5 is one.
// R11 - Ready/busy-only hosts end with 10h; after 15h poll bit 5 first.
// R12 - Erase starts with 60h and two block address cycles.
// R13 - Erase begins only after confirm D0h follows the block address.
// R14 - During erase only read status and reset are accepted.
// R15 - Erase completion shows on ready/busy and bit 6; bit 0 gives result.
// R16 - Status byte appears at the later falling edge of chip select or read strobe.
// R17 - In status mode the status byte updates without toggling strobes.
// R18 - Status mode lasts until another command; issue 00h before reading data.
// R19 - Status bit 7 is zero when write protected; bits 2 to 4 read zero.
// R20 - With write protect low, program and erase do not start.
// R21 - Confirm 10h starts non-cached programming of the loaded page.
module nccs_ctrl (
    // Clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        srst_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // Flash pins
    output logic             cle_o,
    output logic             ale_o,
    output logic             ce_n_o,
    output logic             we_n_o,
    output logic             re_n_o,
    output logic             wp_n_o,
    output logic [7:0]       dq_o,
    output logic             dq_oe_o,
    input  wire logic [7:0]  dq_i,
    input  wire logic        ready_busy_pin_i
);
    import nccs_pkg::*;

    typedef enum logic [3:0] {
        S_IDLE   = 4'b0000,
        S_CMD1   = 4'b0001,
        S_ADDR   = 4'b0011,
        S_DATA   = 4'b0010,
        S_CMD2   = 4'b0110,
        S_WAITWB = 4'b0111,
        S_WAITRB = 4'b0101,
        S_STCMD  = 4'b0100,
        S_STRD   = 4'b1100,
        S_PLCMD  = 4'b1000,
        S_PLRD   = 4'b1001
    } nccs_state_t;

    nccs_cyc_if cyc ();

    nccs_state_t st_reg, st_next;
    nccs_op_t    op_reg, op_next, pend_reg, pend_next;
    logic        iss_reg, iss_next;
    logic [1:0]  aidx_reg, aidx_next;
    logic [11:0] cnt_reg, cnt_next, len_reg, len_next;
    logic [2:0]  wb_reg, wb_next;
    logic [7:0]  opst_reg, opst_next, wdat_reg, wdat_next;
    logic [31:0] addr_reg, addr_next;
    logic [9:0]  blk_reg, blk_next;
    logic        wvld_reg, wvld_next, cact_reg, cact_next;
    logic        poll_reg, poll_next, berr_reg, berr_next, wen_reg, wen_next;
    logic        req_reg, req_next;
    nccs_cyc_t   kind_reg, kind_next;
    logic [7:0]  byte_reg, byte_next;
    logic        rb1_reg, rb2_reg, rb3_reg, rbl_reg;
    logic [31:0] rdat_next;
    logic        rdy_next, err_next, wr_ok, hit;

    assign wr_ok = psel_i && penable_i && pready_o && pwrite_i;
    assign hit   = (paddr_i <= OFS_STAT) && (paddr_i[1:0] == 2'h0);

    // One wait state lets every APB output leave a flop.
    always_comb begin
        rdy_next  = psel_i && penable_i && !pready_o;
        err_next  = rdy_next && !hit;
        rdat_next = 32'h0000_0000;
        if (rdy_next && !pwrite_i) begin
            unique case (paddr_i)
                OFS_CTRL:  rdat_next[CTRL_WEN_BIT] = wen_reg;
                OFS_ADDR:  rdat_next = addr_reg;
                OFS_LEN:   rdat_next[11:0] = len_reg;
                OFS_WDATA: rdat_next[7:0] = wdat_reg;
                OFS_STAT: begin
                    rdat_next[STAT_BUSY_BIT]  = (st_reg != S_IDLE) || (pend_reg != OP_NONE);
                    rdat_next[STAT_DREQ_BIT]  = (st_reg == S_DATA) && !wvld_reg;
                    rdat_next[STAT_RB_BIT]    = rbl_reg;
                    rdat_next[STAT_BERR_BIT]  = berr_reg;
                    rdat_next[STAT_POLL_BIT]  = poll_reg;
                    rdat_next[STAT_CACHE_BIT] = cact_reg;
                    rdat_next[STAT_OPST_LSB +: 8] = opst_reg & 8'hE3; // R19
                end
                default: rdat_next = 32'h0000_0000;
            endcase
        end
    end

    always_comb begin
        st_next   = st_reg;
        op_next   = op_reg;
        pend_next = pend_reg;
        iss_next  = iss_reg;
        aidx_next = aidx_reg;
        cnt_next  = cnt_reg;
        len_next  = len_reg;
        wb_next   = wb_reg;
        opst_next = opst_reg;
        wdat_next = wdat_reg;
        addr_next = addr_reg;
        blk_next  = blk_reg;
        wvld_next = wvld_reg;
        cact_next = cact_reg;
        poll_next = poll_reg;
        berr_next = berr_reg;
        wen_next  = wen_reg;
        req_next  = 1'b0;
        kind_next = kind_reg;
        byte_next = byte_reg;
        // A new block error below beats a clear.
        if (wr_ok && st_reg == S_IDLE && pend_reg == OP_NONE) begin
            addr_next = (paddr_i == OFS_ADDR) ? pwdata_i : addr_reg;
            if (paddr_i == OFS_LEN) begin
                len_next = (pwdata_i[11:0] > PAGE_LAST) ? PAGE_LAST : pwdata_i[11:0]; // R01
            end
        end
        if (wr_ok && paddr_i == OFS_CTRL) begin
            wen_next = pwdata_i[CTRL_WEN_BIT];
            berr_next = berr_reg && !pwdata_i[CTRL_CLR_BIT];
            if (st_reg == S_IDLE && pend_reg == OP_NONE) begin
                pend_next = nccs_op_t'(pwdata_i[CTRL_OP_LSB +: 3]);
            end
        end
        if (wr_ok && paddr_i == OFS_WDATA) begin
            wdat_next = pwdata_i[7:0];
            wvld_next = 1'b1;
        end
        unique case (st_reg)
            S_IDLE: begin
                if (pend_reg != OP_NONE) begin
                    pend_next = OP_NONE;
                    op_next   = pend_reg;
                    if (pend_reg == OP_CACHE && cact_reg && addr_reg[31:BLK_LSB] != blk_reg) begin
                        berr_next = 1'b1; // R02
                    end else if (poll_reg && pend_reg != OP_CACHE && pend_reg != OP_STATUS) begin
                        st_next = S_PLCMD; // R11
                    end else begin
                        st_next = S_CMD1;
                    end
                end
            end
            S_PLCMD, S_STCMD: begin
                req_next  = !iss_reg;
                iss_next  = 1'b1;
                kind_next = CYC_CMD;
                byte_next = CMD_STATUS; // R06
                if (cyc.done) begin
                    iss_next = 1'b0;
                    st_next  = (st_reg == S_PLCMD) ? S_PLRD : S_STRD;
                end
            end
            S_PLRD, S_STRD: begin
                // Status mode persists, so each read sees fresh status.
                req_next  = !iss_reg; // R17
                iss_next  = 1'b1;
                kind_next = CYC_RD; // R16
                if (cyc.done) begin
                    iss_next  = 1'b0;
                    opst_next = cyc.rbyte;
                    if (st_reg == S_STRD) begin
                        st_next = S_IDLE;
                    end else if (cyc.rbyte[ST_ARRAY_IDL]) begin
                        poll_next = 1'b0; // R08
                        st_next   = S_CMD1;
                    end
                end
            end
            S_CMD1: begin
                req_next  = !iss_reg;
                iss_next  = 1'b1;
                kind_next = CYC_CMD;
                unique case (op_reg)
                    OP_ERASE:  byte_next = CMD_ERASE_SET; // R12
                    OP_STATUS: byte_next = CMD_STATUS;
                    OP_RDMODE: byte_next = CMD_READ; // R18
                    default:   byte_next = CMD_SERIAL_IN; // R03
                endcase
                if (cyc.done) begin
                    iss_next  = 1'b0;
                    aidx_next = (op_reg == OP_ERASE) ? 2'h2 : 2'h0;
                    unique case (op_reg)
                        OP_STATUS: st_next = S_STRD;
                        OP_RDMODE: st_next = S_IDLE;
                        default:   st_next = S_ADDR;
                    endcase
                end
            end
            S_ADDR: begin
                req_next  = !iss_reg;
                iss_next  = 1'b1;
                kind_next = CYC_ADDR;
                byte_next = addr_reg[8 * aidx_reg +: 8]; // R03
                if (cyc.done) begin
                    iss_next  = 1'b0;
                    aidx_next = aidx_reg + 2'h1;
                    cnt_next  = 12'h000;
                    if (aidx_reg == 2'h3) begin
                        st_next = (op_reg == OP_ERASE || len_reg == 12'h000) ? S_CMD2 : S_DATA;
                    end
                end
            end
            S_DATA: begin
                kind_next = CYC_WR;
                byte_next = wdat_reg;
                if (!iss_reg && wvld_reg) begin
                    req_next  = 1'b1;
                    iss_next  = 1'b1;
                    wvld_next = 1'b0;
                end
                if (cyc.done) begin
                    iss_next = 1'b0;
                    cnt_next = cnt_reg + 12'h001;
                    if (cnt_reg + 12'h001 == len_reg) begin
                        st_next = S_CMD2;
                    end
                end
            end
            S_CMD2: begin
                req_next  = !iss_reg;
                iss_next  = 1'b1;
                kind_next = CYC_CMD;
                unique case (op_reg)
                    OP_CACHE: byte_next = CMD_CACHE_WR; // R04
                    OP_ERASE: byte_next = CMD_ERASE_CNF; // R13
                    default:  byte_next = CMD_PROG_CONF; // R21
                endcase
                if (cyc.done) begin
                    iss_next  = 1'b0;
                    wb_next   = 3'h0;
                    st_next   = S_WAITWB;
                    cact_next = (op_reg == OP_CACHE);
                    poll_next = (op_reg == OP_CACHE); // R11
                    blk_next  = addr_reg[31:BLK_LSB];
                end
            end
            S_WAITWB: begin
                wb_next = wb_reg + 3'h1;
                if (wb_reg == 3'(WB_CYC - 1)) begin
                    st_next = S_WAITRB;
                end
            end
            S_WAITRB: begin
                // Nothing is issued until ready returns; then the status command follows.
                if (rbl_reg) begin
                    st_next = S_STCMD; // R14
                end
            end
            default: st_next = S_IDLE;
        endcase
    end

    assign cyc.req   = req_reg;
    assign cyc.kind  = kind_reg;
    assign cyc.wbyte = byte_reg;
    assign cyc.ce_en = (st_reg != S_IDLE);

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            st_reg    <= S_IDLE;
            op_reg    <= OP_NONE;
            pend_reg  <= OP_NONE;
            iss_reg   <= 1'b0;
            aidx_reg  <= 2'h0;
            cnt_reg   <= 12'h000;
            len_reg   <= 12'h000;
            wb_reg    <= 3'h0;
            opst_reg  <= 8'h00;
            wdat_reg  <= 8'h00;
            addr_reg  <= 32'h0000_0000;
            blk_reg   <= 10'h000;
            wvld_reg  <= 1'b0;
            cact_reg  <= 1'b0;
            poll_reg  <= 1'b0;
            berr_reg  <= 1'b0;
            wen_reg   <= CTRL_WEN_RST;
            req_reg   <= 1'b0;
            kind_reg  <= CYC_CMD;
            byte_reg  <= 8'h00;
            rb1_reg   <= 1'b0;
            rb2_reg   <= 1'b0;
            rb3_reg   <= 1'b0;
            rbl_reg   <= 1'b0;
            wp_n_o    <= 1'b0;
            prdata_o  <= 32'h0000_0000;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            st_reg    <= st_next;
            op_reg    <= op_next;
            pend_reg  <= pend_next;
            iss_reg   <= iss_next;
            aidx_reg  <= aidx_next;
            cnt_reg   <= cnt_next;
            len_reg   <= len_next;
            wb_reg    <= wb_next;
            opst_reg  <= opst_next;
            wdat_reg  <= wdat_next;
            addr_reg  <= addr_next;
            blk_reg   <= blk_next;
            wvld_reg  <= wvld_next;
            cact_reg  <= cact_next;
            poll_reg  <= poll_next;
            berr_reg  <= berr_next;
            wen_reg   <= wen_next;
            req_reg   <= req_next;
            kind_reg  <= kind_next;
            byte_reg  <= byte_next;
            rb1_reg   <= ready_busy_pin_i;
            rb2_reg   <= rb1_reg;
            rb3_reg   <= rb2_reg;
            rbl_reg   <= (rb2_reg == rb3_reg) ? rb3_reg : rbl_reg; // R15
            wp_n_o    <= wen_reg; // R20
            prdata_o  <= rdat_next;
            pready_o  <= rdy_next;
            pslverr_o <= err_next;
        end
    end

    nccs_bus_cycle u_cycle (
        .sys_clk_i (sys_clk_i),
        .srst_i    (srst_i),
        .cyc       (cyc),
        .cle_o     (cle_o),
        .ale_o     (ale_o),
        .ce_n_o    (ce_n_o),
        .we_n_o    (we_n_o),
        .re_n_o    (re_n_o),
        .dq_o      (dq_o),
        .dq_oe_o   (dq_oe_o),
        .dq_i      (dq_i)
    );
endmodule

// ==== nccs_ctrl_properties.sv ====
// Concurrent checks on the controller's APB and flash pins.
module nccs_ctrl_properties (
    // Clock, reset and APB
    input wire logic       sys_clk_i,
    input wire logic       srst_i,
    input wire logic       psel_i,
    input wire logic       penable_i,
    input wire logic       pready_o,
    input wire logic       pslverr_o,
    // Flash pins
    input wire logic       cle_o,
    input wire logic       ale_o,
    input wire logic       ce_n_o,
    input wire logic       we_n_o,
    input wire logic       re_n_o,
    input wire logic       dq_oe_o,
    input wire logic [7:0] dq_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);
    apb_wait_a: assert property ($rose(penable_i) && psel_i |=> pready_o ##1 !pready_o)
        else $error("APB answer not one wait state");
    apb_err_a: assert property (pslverr_o |-> pready_o && psel_i && penable_i)
        else $error("Slave error outside an answer");
    cmd_pins_a: assert property (!we_n_o |-> !ce_n_o && re_n_o && dq_oe_o)
        else $error("Write strobe misdriven");
    latch_excl_a: assert property (!(cle_o && ale_o))
        else $error("Command and address latch together");
    we_pulse_a: assert property ($fell(we_n_o) |=> !we_n_o ##1 we_n_o)
        else $error("Write strobe low phase wrong");
    re_pulse_a: assert property ($fell(re_n_o) |=> !re_n_o [*3] ##1 re_n_o)
        else $error("Read strobe low phase wrong");
    dq_hold_a: assert property ($rose(we_n_o) |-> $stable(dq_o) && $stable(cle_o))
        else $error("Data moved at write strobe rise");
    rd_release_a: assert property (!re_n_o |-> !dq_oe_o && !ce_n_o && !cle_o && !ale_o)
        else $error("Read cycle with bus driven");
    cover property ($fell(we_n_o) && cle_o);
    cover property ($fell(re_n_o));
    cover property (pslverr_o);
endmodule

bind nccs_ctrl nccs_ctrl_properties u_props (.sys_clk_i, .srst_i, .psel_i, .penable_i, .pready_o, .pslverr_o,
    .cle_o, .ale_o, .ce_n_o, .we_n_o, .re_n_o, .dq_oe_o, .dq_o);

// ==== nccs_ctrl_tb.sv ====
// Self-checking bench for the NAND cache program and erase controller.
module nccs_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import nccs_pkg::*;
    typedef struct {logic w; logic [7:0] a; logic [31:0] d, q; logic e;} nccs_row_t;
    logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, fail = 1'b0, err;
    logic [7:0]  paddr = 8'h00, dq_o, dq_i, starts;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, cle, ce_n, we_n, re_n, wp_n, rb;
    int          err_count = 0, comparisons = 0, cyc = 0;
    nccs_row_t   rows [5] = '{'{1'b0, OFS_CTRL, 32'h0, 32'h0, 1'b0}, '{1'b1, OFS_CTRL, 32'h100, 32'h0, 1'b0},
        '{1'b0, OFS_CTRL, 32'h0, 32'h100, 1'b0}, '{1'b1, OFS_STAT, 32'hFF, 32'h0, 1'b0},
        '{1'b0, 8'h14, 32'h0, 32'h0, 1'b1}};
    nccs_ctrl dut (.sys_clk_i(clk), .srst_i(rst), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .cle_o(cle), .ale_o(), .ce_n_o(ce_n), .we_n_o(we_n), .re_n_o(re_n), .wp_n_o(wp_n),
        .dq_o(dq_o), .dq_oe_o(), .dq_i(dq_i), .ready_busy_pin_i(rb));
    nccs_flash_model model (.clk_i(clk), .cle_i(cle), .ce_n_i(ce_n), .we_n_i(we_n), .re_n_i(re_n),
        .wp_n_i(wp_n), .din_i(dq_o), .fail_i(fail), .dq_o(dq_i), .rb_o(rb), .starts_o(starts));
    initial forever #10 clk = ~clk;
    task tally_and_finish();
        if (err_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            tally_and_finish();
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task run(input logic [31:0] ctrl, input int n, input logic [7:0] st, input logic [7:0] ns);
        apb(1'b1, OFS_CTRL, ctrl);
        for (int i = 0; i < n; i++) begin
            do apb(1'b0, OFS_STAT, 32'h0); while (rd[STAT_DREQ_BIT] !== 1'b1);
            apb(1'b1, OFS_WDATA, 32'(i));
        end
        do apb(1'b0, OFS_STAT, 32'h0); while (rd[STAT_BUSY_BIT] !== 1'b0);
        chk(32'(rd[15:8]), 32'(st));
        chk(32'(starts), 32'(ns));
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        chk({28'h0, ce_n, we_n, re_n, wp_n}, 32'hE);
        foreach (rows[k]) begin
            apb(rows[k].w, rows[k].a, rows[k].d);
            chk(32'(err), 32'(rows[k].e));
            if (!rows[k].w && !rows[k].e) chk(rd, rows[k].q);
        end
        apb(1'b1, OFS_LEN, 32'h2);
        fail <= 1'b1;
        run(32'h102, 2, 8'hE1, 8'h1);
        run(32'h101, 2, 8'hC3, 8'h1);
        fail <= 1'b0;
        run(32'h101, 2, 8'hC2, 8'h1);
        apb(1'b1, OFS_ADDR, 32'h00400000);
        apb(1'b1, OFS_CTRL, 32'h101);
        apb(1'b0, OFS_STAT, 32'h0);
        chk(32'(rd[STAT_BERR_BIT]), 32'h1);
        apb(1'b1, OFS_CTRL, 32'h300);
        apb(1'b1, OFS_ADDR, 32'h0);
        run(32'h102, 2, 8'hE2, 8'h2);
        run(32'h003, 0, 8'h62, 8'h2);
        fail <= 1'b1;
        run(32'h103, 0, 8'hE3, 8'h3);
        run(32'h104, 0, 8'hE3, 8'h3);
        run(32'h105, 0, 8'hE3, 8'h3);
        tally_and_finish();
    end
endmodule

// ==== nccs_cyc_if.sv ====
// Bus-cycle request channel between sequencer and pin engine.
interface nccs_cyc_if;
    logic                 req;
    nccs_pkg::nccs_cyc_t  kind;
    logic [7:0]           wbyte;
    logic                 ce_en;
    logic                 done;
    logic [7:0]           rbyte;
    modport seq (output req, kind, wbyte, ce_en, input done, rbyte);
    modport eng (input req, kind, wbyte, ce_en, output done, rbyte);
endinterface

// ==== nccs_flash_model.sv ====
// Behavioural flash device answering the controller's pin cycles.
module nccs_flash_model (
    // Pins from the controller
    input  wire logic       clk_i,
    input  wire logic       cle_i,
    input  wire logic       ce_n_i,
    input  wire logic       we_n_i,
    input  wire logic       re_n_i,
    input  wire logic       wp_n_i,
    input  wire logic [7:0] din_i,
    input  wire logic       fail_i,
    // Pins to the controller
    output logic [7:0]      dq_o,
    output logic            rb_o,
    output logic [7:0]      starts_o = 8'h00
);
    import nccs_pkg::*;
    logic       we_q = 1'b1, stat_mode = 1'b0, armed = 1'b0, f_cur = 1'b0, f_prev = 1'b0;
    logic [7:0] cache_cnt = 8'h00, prog_cnt = 8'h00, last = 8'h00;
    // Page data is not stored; only register timing is modelled.
    assign rb_o = cache_cnt == 8'h00;
    // Released lines show the inverse of the last value.
    assign dq_o = (!ce_n_i && !re_n_i && stat_mode) ?
        {wp_n_i, cache_cnt == 8'h00, prog_cnt == 8'h00, 3'h0, f_prev, f_cur} : ~last;
    always @(posedge clk_i) begin
        we_q <= we_n_i;
        last <= dq_o;
        if (cache_cnt != 8'h00) cache_cnt <= cache_cnt - 8'h01;
        if (prog_cnt != 8'h00) prog_cnt <= prog_cnt - 8'h01;
        if (!we_q && we_n_i && cle_i && !ce_n_i) begin
            stat_mode <= din_i == CMD_STATUS;
            armed <= din_i == CMD_ERASE_SET;
            if (wp_n_i && cache_cnt == 8'h00) begin
                if (din_i == CMD_CACHE_WR) begin
                    cache_cnt <= prog_cnt + 8'h04;
                    prog_cnt <= prog_cnt + 8'h60;
                    f_prev <= f_cur;
                    f_cur <= fail_i;
                end
                if (din_i == CMD_PROG_CONF || (din_i == CMD_ERASE_CNF && armed)) begin
                    cache_cnt <= prog_cnt + 8'h20;
                    f_cur <= fail_i;
                    starts_o <= starts_o + 8'h01;
                end
            end
        end
    end
endmodule

// ==== nccs_pkg.sv ====
// Shared constants and types for the NAND cache-program and erase controller.
package nccs_pkg;
    // Clock and pin timing.
    localparam int CLK_PERIOD_NS = 20;
    localparam int STROBE_NS     = 40;
    localparam int STROBE_CYC    = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WB_NS         = 100;
    localparam int WB_CYC        = (WB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Page geometry.
    localparam int          PAGE_BYTES = 2112;
    localparam logic [11:0] PAGE_LAST  = 12'(PAGE_BYTES);

    // Register offsets of the controller.
    localparam logic [7:0] OFS_CTRL  = 8'h00;
    localparam logic [7:0] OFS_ADDR  = 8'h04;
    localparam logic [7:0] OFS_LEN   = 8'h08;
    localparam logic [7:0] OFS_WDATA = 8'h0C;
    localparam logic [7:0] OFS_STAT  = 8'h10;

    // Control register fields.
    localparam int CTRL_OP_LSB  = 0;
    localparam int CTRL_WEN_BIT = 8;
    localparam int CTRL_CLR_BIT = 9;
    localparam logic CTRL_WEN_RST = 1'b0;

    // Status register fields.
    localparam int STAT_BUSY_BIT  = 0;
    localparam int STAT_DREQ_BIT  = 1;
    localparam int STAT_RB_BIT    = 2;
    localparam int STAT_BERR_BIT  = 3;
    localparam int STAT_POLL_BIT  = 4;
    localparam int STAT_CACHE_BIT = 5;
    localparam int STAT_OPST_LSB  = 8;

    // Device status byte bits.
    localparam int ST_ARRAY_IDL = 5;

    // Block field inside the 32-bit address register (row bits 15:6).
    localparam int BLK_LSB = 22;

    // Device commands.
    localparam logic [7:0] CMD_SERIAL_IN = 8'h80;
    localparam logic [7:0] CMD_CACHE_WR  = 8'h15;
    localparam logic [7:0] CMD_PROG_CONF = 8'h10;
    localparam logic [7:0] CMD_ERASE_SET = 8'h60;
    localparam logic [7:0] CMD_ERASE_CNF = 8'hD0;
    localparam logic [7:0] CMD_STATUS    = 8'h70;
    localparam logic [7:0] CMD_READ      = 8'h00;

    typedef enum logic [2:0] {
        OP_NONE   = 3'h0,
        OP_CACHE  = 3'h1,
        OP_PAGE   = 3'h2,
        OP_ERASE  = 3'h3,
        OP_STATUS = 3'h4,
        OP_RDMODE = 3'h5
    } nccs_op_t;

    typedef enum logic [1:0] {
        CYC_CMD  = 2'h0,
        CYC_ADDR = 2'h1,
        CYC_WR   = 2'h2,
        CYC_RD   = 2'h3
    } nccs_cyc_t;
endpackage
